// ==== src/dci_consts.svh ====
`ifndef DCI_CONSTS_SVH
`define DCI_CONSTS_SVH
// Register byte addresses
`define DCI_ADR_CTRL 4'h0
`define DCI_ADR_STAT 4'h4
// Control register reset value: external clock, dual bus, 2x
`define DCI_CTRL_RST 8'h00
// Status field positions
`define DCI_ST_MODE_LO 0
`define DCI_ST_INVALID 2
`define DCI_ST_EMPTY 3
`define DCI_ST_OVF 8
// Byte lane that holds the overflow flag
`define DCI_SEL_OVF 1
// Bus mode codes
`define DCI_BUS_DUAL 2'h0
`define DCI_BUS_ILV_A 2'h1
`define DCI_BUS_ILV_B 2'h2
`define DCI_BUS_HALF 2'h3
// Interpolation select codes
`define DCI_INTERP_2X 2'h0
`define DCI_INTERP_4X 2'h1
// Sample-clock cycles per data word at each interpolation
`define DCI_RATIO_2X 5'h02
`define DCI_RATIO_4X 5'h04
`define DCI_RATIO_8X 5'h08
`define DCI_HALF_MIN 5'h01
// Sample word sign bit used as the A/B marker
`define DCI_MSB 15
`endif

// ==== src/dci_pkg.sv ====
package dci_pkg;
  // Control byte layout, top bit first
  typedef struct packed {
    logic [1:0] interp_sel;
    logic aflag_sel;
    logic [1:0] bus_mode;
    logic dualclk_ena;
    logic clko_off;
    logic synchr_clkin;
  } dci_cfg_t;

  typedef enum logic [1:0] {
    DCI_CM_NONE,
    DCI_CM_DUAL_SYNC,
    DCI_CM_DUAL,
    DCI_CM_EXT
  } dci_mode_t;

  // One buffered transfer; half marks two successive A samples
  typedef struct packed {
    logic half;
    logic [15:0] a;
    logic [15:0] b;
  } dci_word_t;

  // Only the three listed patterns are legal; no multiplier mode exists
  function automatic dci_mode_t dci_decode_mode(input dci_cfg_t c);
    logic [2:0] p;
    p = {c.synchr_clkin, c.clko_off, c.dualclk_ena};
    if (p == 3'h7) return DCI_CM_DUAL_SYNC;
    else if (p == 3'h3) return DCI_CM_DUAL;
    else if (p == 3'h0) return DCI_CM_EXT;
    else return DCI_CM_NONE;
  endfunction : dci_decode_mode
endpackage : dci_pkg

// ==== src/dci_top.sv ====
// The placing of the registers and the Wishbone register port were left to the implementer.
`include "dci_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// Three-stage crossing; output follows once stages two and three agree
module dci_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q, s2_q, s3_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) q <= s3_q;
    end
  end
endmodule : dci_sync3

module dci_top #(
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic data_rate_clock_in,
  input wire logic [15:0] first_input_port,
  input wire logic [15:0] second_input_port,
  input wire logic transmit_gate,
  input wire logic resync_in,
  output logic data_clock_pin_o,
  output logic data_clock_pin_oe_n,
  output logic [15:0] chan_a_o,
  output logic [15:0] chan_b_o,
  output logic chan_a_valid_o,
  output logic chan_b_valid_o
);
  import dci_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;

  // Pointer arithmetic needs a power of two of at least two entries
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("dci_top: DEPTH must be a power of two, at least 2");
  end

  function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = g[i] ^ b[i+1];
    end
    return b;
  endfunction : g2b

  // Buffer storage, written on the link clock, read on clk
  dci_word_t mem [DEPTH];

  // ---------------- Register side (clk) ----------------
  dci_cfg_t cfg_q;
  logic ack_q, ovf_q, ovf_seen_q;
  logic [31:0] dat_q;
  dci_mode_t mode;
  logic req, wr_ctrl, wr_stat, ovf_ev, fifo_empty;
  logic [31:0] rdata, stat_word;

  assign mode = dci_decode_mode(cfg_q);
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_ctrl = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `DCI_ADR_CTRL);
  assign wr_stat = req & wb_we_i & wb_sel_i[`DCI_SEL_OVF] & (wb_adr_i == `DCI_ADR_STAT);
  assign stat_word = (32'(mode) << `DCI_ST_MODE_LO) | (32'(mode == DCI_CM_NONE) << `DCI_ST_INVALID)
    | (32'(fifo_empty) << `DCI_ST_EMPTY) | (32'(ovf_q) << `DCI_ST_OVF);
  // Unmapped addresses are acknowledged and read as zero
  assign rdata = (wb_adr_i == `DCI_ADR_CTRL) ? {24'h000000, cfg_q}
    : (wb_adr_i == `DCI_ADR_STAT) ? stat_word : 32'h00000000;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Single-wait-state slave: ack one edge after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      cfg_q <= dci_cfg_t'(`DCI_CTRL_RST);
    end else begin
      ack_q <= req;
      if (req) dat_q <= rdata;
      if (wr_ctrl) cfg_q <= dci_cfg_t'(wb_dat_i[7:0]);
    end
  end

  // Overflow flag: a new event beats a write-one-to-clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ovf_q <= 1'b0;
    else ovf_q <= ovf_ev | (ovf_q & ~(wr_stat & wb_dat_i[`DCI_ST_OVF]));
  end

  // ---------------- Data clock output (clk) ----------------
  logic [4:0] ratio, half_per, div_cnt_q;
  logic div_q;

  assign ratio = (cfg_q.interp_sel == `DCI_INTERP_2X) ? `DCI_RATIO_2X
    : (cfg_q.interp_sel == `DCI_INTERP_4X) ? `DCI_RATIO_4X : `DCI_RATIO_8X;
  // Interleaving doubles the word rate except at 2x, where the half period stays at one; half-rate bus halves it
  assign half_per = (cfg_q.bus_mode == `DCI_BUS_HALF) ? ratio
    : (cfg_q.bus_mode == `DCI_BUS_DUAL) ? (ratio >> 1)
    : ((ratio >> 2) == 5'h00 ? `DCI_HALF_MIN : (ratio >> 2));
  assign data_clock_pin_o = div_q;
  assign data_clock_pin_oe_n = (mode != DCI_CM_EXT);

  // Divider runs only while the pin is an output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 5'h00;
      div_q <= 1'b0;
    end else if (mode != DCI_CM_EXT) begin
      div_cnt_q <= 5'h00;
      div_q <= 1'b0;
    end else if (div_cnt_q >= half_per - `DCI_HALF_MIN) begin
      div_cnt_q <= 5'h00;
      div_q <= ~div_q;
    end else begin
      div_cnt_q <= div_cnt_q + 5'h01;
    end
  end

  // Edges since the pin last moved; keeps the stuck-pin check free of long repeats
  logic div_prev_q;
  logic [3:0] still_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_prev_q <= 1'b0;
      still_q <= 4'h0;
    end else begin
      div_prev_q <= div_q;
      if (mode != DCI_CM_EXT || div_q != div_prev_q) still_q <= 4'h0;
      else if (still_q != 4'hF) still_q <= still_q + 4'h1;
    end
  end

  // ---------------- Link side (data_rate_clock_in) ----------------
  logic [1:0] lrst_q;
  logic link_rst;
  dci_cfg_t lk_cfg;
  dci_mode_t lk_mode;
  logic [PW-1:0] wbin_q, wgray_q, rgray_q, rgray_s, rbin_s;
  logic gate_q, phase_q, tog_q, ovf_tog_q;
  logic [15:0] hold_a_q, stream;
  logic ilv, gate_rise, is_a, want, full, push;
  dci_word_t wword;

  // Reset released in step with the link clock
  always_ff @(posedge data_rate_clock_in or posedge rst) begin
    if (rst) lrst_q <= 2'h3;
    else lrst_q <= {lrst_q[0], 1'b0};
  end
  assign link_rst = lrst_q[1];

  // Configuration is quasi-static while transfers are stopped
  dci_sync3 #(.W(8)) u_cfg_sync (.clk(data_rate_clock_in), .rst(link_rst), .d(cfg_q), .q(lk_cfg));
  dci_sync3 #(.W(PW)) u_rp_sync (.clk(data_rate_clock_in), .rst(link_rst), .d(rgray_q),
    .q(rgray_s));

  assign lk_mode = dci_decode_mode(lk_cfg);
  assign rbin_s = g2b(rgray_s);
  assign ilv = (lk_cfg.bus_mode == `DCI_BUS_ILV_A) | (lk_cfg.bus_mode == `DCI_BUS_ILV_B);
  assign stream = (lk_cfg.bus_mode == `DCI_BUS_ILV_A) ? first_input_port : second_input_port;
  assign gate_rise = transmit_gate & ~gate_q;
  // Marker: gate edge forces A, else alternate; or MSB of the idle port
  assign is_a = lk_cfg.aflag_sel ? (gate_rise | ~phase_q)
    : ((lk_cfg.bus_mode == `DCI_BUS_ILV_A) ? second_input_port[`DCI_MSB]
      : first_input_port[`DCI_MSB]);
  assign want = (lk_mode != DCI_CM_NONE) & (~ilv | ~is_a);
  assign full = (lk_mode != DCI_CM_DUAL_SYNC) & ((wbin_q - rbin_s) == PW'(DEPTH));
  assign push = want & ~full;
  // Word layout per bus mode; half-rate carries two A samples
  assign wword = ilv ? dci_word_t'{half: 1'b0, a: hold_a_q, b: stream}
    : dci_word_t'{half: (lk_cfg.bus_mode == `DCI_BUS_HALF), a: first_input_port,
        b: second_input_port};

  // Interleave tracking
  always_ff @(posedge data_rate_clock_in or posedge link_rst) begin
    if (link_rst) begin
      gate_q <= 1'b0;
      phase_q <= 1'b0;
      hold_a_q <= 16'h0000;
    end else begin
      gate_q <= transmit_gate;
      phase_q <= ilv & is_a;
      if (ilv & is_a) hold_a_q <= stream;
    end
  end

  // Buffer write: fixed entry zero in synchronous mode, ring otherwise
  always_ff @(posedge data_rate_clock_in or posedge link_rst) begin
    if (link_rst) begin
      wbin_q <= '0;
      wgray_q <= '0;
      tog_q <= 1'b0;
      ovf_tog_q <= 1'b0;
    end else begin
      if (want & full) ovf_tog_q <= ~ovf_tog_q;
      if (push && lk_mode == DCI_CM_DUAL_SYNC) begin
        tog_q <= ~tog_q;
      end else if (push) begin
        wbin_q <= wbin_q + PW'(1);
        wgray_q <= (wbin_q + PW'(1)) ^ ((wbin_q + PW'(1)) >> 1);
      end
    end
  end

  // Memory has no reset so it can map onto a register array
  always_ff @(posedge data_rate_clock_in) begin
    if (push) mem[(lk_mode == DCI_CM_DUAL_SYNC) ? AW'(0) : wbin_q[AW-1:0]] <= wword;
  end

  // ---------------- Read side (clk) ----------------
  logic [PW-1:0] rbin_q, wgray_s, wbin_s;
  logic tog_s, tog_seen_q, ovf_tog_s, rs_lvl, rs_prev_q, rs_rise;
  logic half_pend_q, a_val_q, b_val_q, avail, pop;
  logic [15:0] a_q, b_q, half_b_q;
  dci_word_t rword;

  dci_sync3 #(.W(PW)) u_wp_sync (.clk(clk), .rst(rst), .d(wgray_q), .q(wgray_s));
  dci_sync3 #(.W(2)) u_tog_sync (.clk(clk), .rst(rst), .d({ovf_tog_q, tog_q}),
    .q({ovf_tog_s, tog_s}));
  dci_sync3 #(.W(1)) u_rs_sync (.clk(clk), .rst(rst), .d(resync_in), .q(rs_lvl));

  assign wbin_s = g2b(wgray_s);
  assign fifo_empty = (rbin_q == wbin_s);
  assign ovf_ev = (ovf_tog_s != ovf_seen_q);
  assign rs_rise = rs_lvl & ~rs_prev_q;
  assign avail = (mode == DCI_CM_DUAL_SYNC) ? (tog_s != tog_seen_q) : ~fifo_empty;
  assign pop = (mode != DCI_CM_NONE) & ~half_pend_q & avail;
  assign rword = mem[(mode == DCI_CM_DUAL_SYNC) ? AW'(0) : rbin_q[AW-1:0]];
  assign chan_a_o = a_q;
  assign chan_b_o = b_q;
  assign chan_a_valid_o = a_val_q;
  assign chan_b_valid_o = b_val_q;

  // Read pointer; resync pin empties the elastic buffer in dual clock mode only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rbin_q <= '0;
      rgray_q <= '0;
      tog_seen_q <= 1'b0;
      ovf_seen_q <= 1'b0;
      rs_prev_q <= 1'b0;
    end else begin
      rs_prev_q <= rs_lvl;
      ovf_seen_q <= ovf_tog_s;
      if (pop && mode == DCI_CM_DUAL_SYNC) tog_seen_q <= tog_s;
      if (rs_rise && mode == DCI_CM_DUAL) begin
        rbin_q <= wbin_s;
        rgray_q <= wgray_s;
      end else if (pop && mode != DCI_CM_DUAL_SYNC) begin
        rbin_q <= rbin_q + PW'(1);
        rgray_q <= (rbin_q + PW'(1)) ^ ((rbin_q + PW'(1)) >> 1);
      end
    end
  end

  // Sample outputs; half-rate words leave as two A samples in a row
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_q <= 16'h0000;
      b_q <= 16'h0000;
      half_b_q <= 16'h0000;
      a_val_q <= 1'b0;
      b_val_q <= 1'b0;
      half_pend_q <= 1'b0;
    end else begin
      a_val_q <= pop | half_pend_q;
      b_val_q <= pop & ~rword.half;
      half_pend_q <= pop & rword.half;
      if (half_pend_q) a_q <= half_b_q;
      else if (pop) a_q <= rword.a;
      if (pop) begin
        b_q <= rword.half ? 16'h0000 : rword.b;
        half_b_q <= rword.b;
      end
    end
  end

  // ---------------- Checks ----------------
  chk_mode_decode: assert property (@(posedge clk) disable iff (rst)
    (mode == DCI_CM_DUAL_SYNC) == ({cfg_q.synchr_clkin, cfg_q.clko_off, cfg_q.dualclk_ena} == 3'h7))
    else $error("clock mode decode wrong");
  chk_pin_dir: assert property (@(posedge clk) disable iff (rst)
    (mode != DCI_CM_EXT) |-> data_clock_pin_oe_n ##1 (mode == DCI_CM_EXT || !data_clock_pin_o))
    else $error("data clock pin driven outside external mode");
  chk_pin_toggle: assert property (@(posedge clk) disable iff (rst)
    (mode == DCI_CM_EXT) |-> 5'(still_q) <= `DCI_RATIO_8X)
    else $error("data clock pin stuck in external mode");
  chk_invalid_idle: assert property (@(posedge clk) disable iff (rst)
    (mode == DCI_CM_NONE) ##1 (mode == DCI_CM_NONE) |-> !pop ##1 !chan_b_valid_o)
    else $error("data moved under an illegal clock mode");
  chk_resync_flush: assert property (@(posedge clk) disable iff (rst)
    (rs_rise && mode == DCI_CM_DUAL) |=> rbin_q == $past(wbin_s))
    else $error("resync did not empty buffer");
  chk_entry_zero: assert property (@(posedge data_rate_clock_in) disable iff (link_rst)
    (lk_mode == DCI_CM_DUAL_SYNC) && $stable(lk_mode) |-> $stable(wbin_q))
    else $error("sync mode moved write pointer");
  chk_dual_route: assert property (@(posedge data_rate_clock_in) disable iff (link_rst)
    (push && lk_cfg.bus_mode == `DCI_BUS_DUAL) |-> wword.a == first_input_port
      && wword.b == second_input_port && !wword.half)
    else $error("dual bus routing wrong");
  chk_gate_a: assert property (@(posedge data_rate_clock_in) disable iff (link_rst)
    (ilv && lk_cfg.aflag_sel && gate_rise) |=> hold_a_q == $past(stream) && !is_a || gate_rise)
    else $error("gate edge sample not taken as A");
  chk_msb_b: assert property (@(posedge data_rate_clock_in) disable iff (link_rst)
    (ilv && !lk_cfg.aflag_sel && !is_a && !full) |-> push && wword.b == stream
      && wword.a == hold_a_q)
    else $error("MSB-marked B sample not paired");
  chk_half_pair: assert property (@(posedge clk) disable iff (rst)
    (pop && rword.half) |=> a_val_q && !b_val_q ##1 a_val_q && a_q == $past(rword.b, 2))
    else $error("half-rate second sample lost");
  chk_no_overrun: assert property (@(posedge data_rate_clock_in) disable iff (link_rst)
    full |=> wbin_q == $past(wbin_q))
    else $error("write past full");

  cov_dual_pair: cover property (@(posedge clk) disable iff (rst)
    a_val_q && b_val_q && mode == DCI_CM_DUAL);
  cov_half_rate: cover property (@(posedge clk) disable iff (rst) pop && rword.half);
  cov_overflow: cover property (@(posedge clk) disable iff (rst) ovf_ev);
  cov_ext_clock: cover property (@(posedge clk) disable iff (rst)
    mode == DCI_CM_EXT && $rose(div_q));
endmodule : dci_top
`default_nettype wire

// ==== test/dci_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Data source: link clock runs only while a frame is queued or free is high
module dci_src_model (
  input wire logic free,
  output logic lclk,
  output logic [15:0] p1,
  output logic [15:0] p2,
  output logic gate
);
  logic [32:0] q[$];

  task automatic push(input logic [15:0] a, input logic [15:0] b, input logic g);
    q.push_back({g, a, b});
  endtask : push

  // Released lines fall to their pull-down level, so idle words read as zero
  initial begin
    logic [32:0] w;
    lclk = 1'b0;
    {gate, p1, p2} = '0;
    #13; // Phase offset against the sample clock
    forever begin
      if (q.size() > 0 || free) begin
        w = (q.size() > 0) ? q.pop_front() : '0;
        {gate, p1, p2} <= w; // Marker travels with its sample
        #62.5 lclk = 1'b1; // Divided data-rate clock
        #62.5 lclk = 1'b0;
      end else begin
        {gate, p1, p2} <= '0;
        #5;
      end
    end
  end
endmodule : dci_src_model

`default_nettype wire

// ==== test/test_dac_input_clock_and_bus_modes.sv ====
`include "dci_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module test_dac_input_clock_and_bus_modes;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic ack, lclk, drc, gate, pin, pin_oe_n, va, vb;
  logic free = 1'b1, ext_loop = 1'b0, rs = 1'b0;
  logic [15:0] p1, p2, cha, chb;
  logic [15:0] qa[$], qb[$], ea[$], eb[$];
  int errors = 0, n_compared = 0;

  always #25 clk = ~clk;
  // External mode: the DUT link clock input is taken from the driven pin
  assign drc = ext_loop ? pin : lclk;

  dci_src_model model (.free(free), .lclk(lclk), .p1(p1), .p2(p2), .gate(gate));

  dci_top #(.DEPTH(16)) dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .data_rate_clock_in(drc), .first_input_port(p1),
    .second_input_port(p2), .transmit_gate(gate), .resync_in(rs),
    .data_clock_pin_o(pin), .data_clock_pin_oe_n(pin_oe_n), .chan_a_o(cha),
    .chan_b_o(chb), .chan_a_valid_o(va), .chan_b_valid_o(vb));

  // Output monitor; valids stand one cycle
  always @(posedge clk) begin
    if (va === 1'b1) qa.push_back(cha);
    if (vb === 1'b1) qb.push_back(chb);
  end

  task automatic end_sim;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_seq(input string nm, input logic [15:0] e[$], input logic [15:0] g[$]);
    chk({nm, " count"}, e.size(), g.size());
    for (int i = 0; i < e.size() && i < g.size(); i++) chk(nm, e[i], g[i]);
  endtask : chk_seq

  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int k;
    k = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) chk("wb ack", 1, 0);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask : wb

  // Config changes only with traffic stopped, then link settles
  task automatic cfg(input logic [7:0] v);
    wb(1'b1, `DCI_ADR_CTRL, {24'h0, v}, rd);
    free <= 1'b1;
    repeat (20) @(posedge clk);
    free <= 1'b0;
    repeat (20) @(posedge clk);
    qa.delete(); qb.delete(); ea.delete(); eb.delete();
  endtask : cfg

  task automatic drain(input string nm);
    int k;
    k = 0;
    while (model.q.size() > 0 && k < 200) begin @(posedge clk); k++; end
    repeat (30) @(posedge clk);
    chk_seq({nm, " a"}, ea, qa);
    chk_seq({nm, " b"}, eb, qb);
  endtask : drain

  task automatic t_regs;
    wb(1'b0, `DCI_ADR_CTRL, 0, rd);
    chk("ctrl reset", `DCI_CTRL_RST, rd);
    wb(1'b0, `DCI_ADR_STAT, 0, rd);
    chk("stat mode reset", 3'h3, rd[2:0]);
    wb(1'b1, 4'h8, 32'h0000_00FF, rd);
    wb(1'b0, 4'h8, 0, rd);
    chk("unmapped read", 0, rd);
    wb(1'b0, `DCI_ADR_CTRL, 0, rd);
    chk("ctrl after unmapped", `DCI_CTRL_RST, rd);
  endtask : t_regs

  // All eight patterns; only three are modes, none a multiplier
  task automatic t_modes;
    logic [2:0] e;
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, `DCI_ADR_CTRL, i, rd);
      repeat (3) @(posedge clk);
      e = (i == 7) ? 3'h1 : (i == 6) ? 3'h2 : (i == 0) ? 3'h3 : 3'h4;
      wb(1'b0, `DCI_ADR_STAT, 0, rd);
      chk("stat mode", e, rd[2:0]);
      chk("pin oe_n", i != 0, pin_oe_n);
      if (i != 0) chk("pin idle", 0, pin);
    end
  endtask : t_modes

  // Parallel ports in dual or dual synchronous clocking
  task automatic t_par(input logic [7:0] v, input string nm);
    cfg(v);
    if (!v[0]) begin
      rs <= 1'b1; // Pulse outlasts the pin filter
      repeat (6) @(posedge clk);
      rs <= 1'b0;
      repeat (6) @(posedge clk);
      wb(1'b0, `DCI_ADR_STAT, 0, rd);
      chk("stat empty", 1, rd[`DCI_ST_EMPTY]);
    end
    for (int i = 0; i < 4; i++) begin
      model.push(16'h1100 + i, 16'hB200 + i, 1'b0);
      ea.push_back(16'h1100 + i);
      eb.push_back(16'hB200 + i);
      // Entry zero holds one word and bench clocks are not phase locked
      if (v[0]) repeat (12) @(posedge clk);
    end
    drain(nm);
  endtask : t_par

  task automatic t_ilv_gate;
    cfg(8'h2E);
    for (int i = 0; i < 3; i++) begin
      model.push(16'h0A00 + i, 16'h0, 1'b1); // Gate rises with the first A only and stays high after
      model.push(16'hFB00 + i, 16'h0, 1'b1);
      ea.push_back(16'h0A00 + i);
      eb.push_back(16'hFB00 + i);
    end
    drain("ilv gate");
  endtask : t_ilv_gate

  task automatic t_ilv_msb;
    cfg(8'h16);
    for (int i = 0; i < 3; i++) begin
      model.push(16'h8000, 16'h7A00 + i, 1'b0); // Idle port MSB toggles
      model.push(16'h0000, 16'h8B00 + i, 1'b0);
      ea.push_back(16'h7A00 + i);
      eb.push_back(16'h8B00 + i);
    end
    drain("ilv msb");
  endtask : t_ilv_msb

  task automatic t_half;
    cfg(8'h1E);
    for (int i = 0; i < 3; i++) begin
      model.push(16'h3C00 + i, 16'hC300 + i, 1'b0);
      ea.push_back(16'h3C00 + i);
      ea.push_back(16'hC300 + i);
    end
    drain("half");
  endtask : t_half

  // Pin half period in sample cycles for interp and bus mode
  task automatic t_ext;
    logic [7:0] cv[7] = '{8'h00, 8'h40, 8'h80, 8'h48, 8'h88, 8'h18, 8'hD8};
    int hv[7] = '{1, 2, 4, 1, 2, 2, 8};
    int n, k;
    ext_loop <= 1'b1;
    for (int j = 0; j < 7; j++) begin
      wb(1'b1, `DCI_ADR_CTRL, cv[j], rd);
      repeat (12) @(posedge clk);
      n = 0;
      k = 0;
      while (pin !== 1'b0 && k < 100) begin @(posedge clk); k++; end
      while (pin !== 1'b1 && k < 100) begin @(posedge clk); k++; end
      while (pin === 1'b1 && k < 100) begin n++; @(posedge clk); k++; end
      chk("pin half period", hv[j], n);
      chk("pin oe_n ext", 0, pin_oe_n);
    end
    ext_loop <= 1'b0;
  endtask : t_ext

  initial begin
    #2ms;
    errors++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge clk);
    repeat (3) @(posedge drc);
    @(posedge clk);
    rst <= 1'b0;
    free <= 1'b0;
    @(posedge clk);
    t_regs();
    t_modes();
    t_par(8'h06, "dual");
    t_par(8'h07, "dual sync");
    t_ilv_gate();
    t_ilv_msb();
    t_half();
    t_ext();
    end_sim();
  end
endmodule : test_dac_input_clock_and_bus_modes

`default_nettype wire
